// ### pkg/gpe_pkg.sv
// Package for the 16-pin port block: register map, field widths, reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// How it works
// - Line A mask gates each latched event.
// - Events latch regardless of either mask.
// - Independent line B mask, 1 enables.
// - Level register reads zero when input disabled.
// - Selected edge sets the pin flag.
// - Flags stay set until software clears.
// - Writing 1 clears flag, 0 ignored.
// - Drive enable bit turns driver on.
// - Output data bit sets pin level.
// - Pull enable bit turns pull on.
// - Polarity 0 falling, 1 rising edge.
// - Input enable gates the input path.
package gpe_pkg;
   localparam int GPE_PINS = 16;
   localparam int GPE_AW = 8;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] GPE_OFS_IRQ_A_MASK = 8'h00;
   localparam logic [7:0] GPE_OFS_IRQ_B_MASK = 8'h04;
   localparam logic [7:0] GPE_OFS_LEVEL = 8'h08;
   localparam logic [7:0] GPE_OFS_FLAGS = 8'h0c;
   localparam logic [7:0] GPE_OFS_DRIVE_EN = 8'h10;
   localparam logic [7:0] GPE_OFS_DRIVE_LVL = 8'h14;
   localparam logic [7:0] GPE_OFS_PULL_EN = 8'h18;
   localparam logic [7:0] GPE_OFS_POLARITY = 8'h1c;
   localparam logic [7:0] GPE_OFS_INPUT_EN = 8'h20;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] GPE_RST_ZERO = 16'h0000;
   localparam logic [15:0] GPE_RST_INPUT_EN = 16'h0000;

   typedef struct packed {
      logic [15:0] drive_level;
      logic [15:0] drive_enable_n;
      logic [15:0] pull_enable;
   } gpe_pad_out_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [GPE_AW-1:0] adr;
      logic [31:0] dat;
   } gpe_wb_req_type;
endpackage

// ### rtl/gpe_pin_event.sv
// One pin's edge detector and sticky event flag.
// Assumes the pin level is already synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module gpe_pin_event (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic level,
   input wire logic polarity,
   input wire logic clear,
   output logic flag_q
);
   logic prev_q;
   logic hit;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   assign hit = polarity ? (level & ~prev_q) : (~level & prev_q);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
      end else if (hit) begin
         flag_q <= 1'b1;
      end else if (clear) begin
         flag_q <= 1'b0;
      end
   end

   AST_SET_ON_EDGE: assert property (@(posedge core_clk) disable iff (!reset_n)
      hit |=> flag_q) else $error("edge did not set flag");
   AST_STICKY: assert property (@(posedge core_clk) disable iff (!reset_n)
      (flag_q && !clear) |=> flag_q) else $error("flag dropped without clear");
endmodule
`default_nettype wire

// ### rtl/gpe_port.sv
// Top of the 16-pin port: Wishbone register file, pad controls, event flags.
// Assumes pins are synchronous to core_clk and the bus is classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
module gpe_port (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire gpe_pkg::gpe_wb_req_type wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] pin_in,
   output gpe_pkg::gpe_pad_out_type pad_out,
   output logic irq_a,
   output logic irq_b
);
   import gpe_pkg::*;

   logic [15:0] irq_a_mask_q;
   logic [15:0] irq_b_mask_q;
   logic [15:0] drive_en_q;
   logic [15:0] drive_lvl_q;
   logic [15:0] pull_en_q;
   logic [15:0] polarity_q;
   logic [15:0] input_en_q;
   logic [15:0] level_q;
   logic [15:0] flags;
   logic [15:0] clr;
   logic [15:0] wmask;
   logic [15:0] gated;
   logic access;
   logic wr;
   logic [31:0] rd_d;

   // ----------------------------------------
   // Bus access
   // ----------------------------------------
   // Ack comes one cycle after the request and drops the cycle after.
   assign access = wb_req.cyc & wb_req.stb & ~wb_ack_o;
   assign wr = access & wb_req.we;
   assign wmask = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // writable controls
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_a_mask_q <= GPE_RST_ZERO;
         irq_b_mask_q <= GPE_RST_ZERO;
         drive_en_q <= GPE_RST_ZERO;
         drive_lvl_q <= GPE_RST_ZERO;
         pull_en_q <= GPE_RST_ZERO;
         polarity_q <= GPE_RST_ZERO;
         input_en_q <= GPE_RST_INPUT_EN;
      end else if (wr) begin
         case (wb_req.adr)
            GPE_OFS_IRQ_A_MASK: irq_a_mask_q <= (irq_a_mask_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            GPE_OFS_IRQ_B_MASK: irq_b_mask_q <= (irq_b_mask_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            GPE_OFS_DRIVE_EN: drive_en_q <= (drive_en_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            GPE_OFS_DRIVE_LVL: drive_lvl_q <= (drive_lvl_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            GPE_OFS_PULL_EN: pull_en_q <= (pull_en_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            GPE_OFS_POLARITY: polarity_q <= (polarity_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            GPE_OFS_INPUT_EN: input_en_q <= (input_en_q & ~wmask) | (wb_req.dat[15:0] & wmask);
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Input path and events
   // ----------------------------------------
   // input gating
   assign gated = pin_in & input_en_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_q <= GPE_RST_ZERO;
      end else begin
         level_q <= gated;
      end
   end

   assign clr = (wr && wb_req.adr == GPE_OFS_FLAGS) ? (wb_req.dat[15:0] & wmask) : 16'h0000;

   // Events are taken from the registered gated level, so disabling a high input gives one falling edge; after that it cannot fire until re-enabled.
   // flags ignore masks
   genvar i;
   generate
      for (i = 0; i < GPE_PINS; i++) begin : g_pin
         gpe_pin_event u_evt (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .level(level_q[i]),
            .polarity(polarity_q[i]),
            .clear(clr[i]),
            .flag_q(flags[i])
         );
      end
   endgenerate

   assign irq_a = |(flags & irq_a_mask_q);
   assign irq_b = |(flags & irq_b_mask_q);

   // ----------------------------------------
   // Pads and read data
   // ----------------------------------------
   // pad controls, enable low means driving
   assign pad_out.drive_level = drive_lvl_q;
   assign pad_out.drive_enable_n = ~drive_en_q;
   assign pad_out.pull_enable = pull_en_q;

   always_comb begin
      rd_d = 32'h0000_0000;
      case (wb_req.adr)
         GPE_OFS_IRQ_A_MASK: rd_d[15:0] = irq_a_mask_q;
         GPE_OFS_IRQ_B_MASK: rd_d[15:0] = irq_b_mask_q;
         GPE_OFS_LEVEL: rd_d[15:0] = level_q;
         GPE_OFS_FLAGS: rd_d[15:0] = flags;
         GPE_OFS_DRIVE_EN: rd_d[15:0] = drive_en_q;
         GPE_OFS_DRIVE_LVL: rd_d[15:0] = drive_lvl_q;
         GPE_OFS_PULL_EN: rd_d[15:0] = pull_en_q;
         GPE_OFS_POLARITY: rd_d[15:0] = polarity_q;
         GPE_OFS_INPUT_EN: rd_d[15:0] = input_en_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (access && !wb_req.we) begin
         wb_dat_o <= rd_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_IRQ_A: assert property (@(posedge core_clk) disable iff (!reset_n)
      irq_a == |(flags & irq_a_mask_q)) else $error("line A mismatch");
   AST_IRQ_B_MASKED: assert property (@(posedge core_clk) disable iff (!reset_n)
      (irq_b_mask_q == 16'h0000) |-> !irq_b) else $error("line B fired while masked");
   AST_LEVEL_GATED: assert property (@(posedge core_clk) disable iff (!reset_n)
      (level_q & ~$past(input_en_q)) == 16'h0000) else $error("level visible while disabled");
   AST_FLAG_NO_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
      (level_q[0] && !$past(level_q[0]) && polarity_q[0]) |=> flags[0])
      else $error("rising event lost");
   AST_W1C: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clr[0] && flags[0] && !(polarity_q[0] ? (level_q[0] && !$past(level_q[0]))
      : (!level_q[0] && $past(level_q[0])))) |=> !flags[0]) else $error("flag not cleared");
   AST_DRIVE_EN: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_DRIVE_EN && wmask == 16'hffff)
      |=> pad_out.drive_enable_n == ~$past(wb_req.dat[15:0])) else $error("drive enable wrong");
   AST_DRIVE_LVL: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_DRIVE_LVL && wmask == 16'hffff)
      |=> pad_out.drive_level == $past(wb_req.dat[15:0])) else $error("drive level wrong");
   AST_PULL: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_PULL_EN && wmask == 16'hffff)
      |=> pad_out.pull_enable == $past(wb_req.dat[15:0])) else $error("pull enable wrong");
   AST_FALLING: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!level_q[1] && $past(level_q[1]) && !polarity_q[1]) |=> flags[1])
      else $error("falling event lost");
   AST_ACK: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o) else $error("ack late");

   // ----------------------------------------
   // Bus timing checks
   // ----------------------------------------
   // A held request must not be taken twice, so ack is a single-cycle pulse.
   AST_ACK_PULSE: assert property (@(posedge core_clk) disable iff (!reset_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stayed high");

   // Read data is held between reads so a slow master still sees the last value.
   AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
      !(access && !wb_req.we) |=> $stable(wb_dat_o))
      else $error("read data changed without a read");

   // ----------------------------------------
   // Register readback checks
   // ----------------------------------------
   // Each read returns the addressed register, upper half zero.
   AST_RD_A_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_IRQ_A_MASK) |=> wb_dat_o == {16'h0000, $past(irq_a_mask_q)})
      else $error("line A mask readback wrong");
   AST_RD_B_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_IRQ_B_MASK) |=> wb_dat_o == {16'h0000, $past(irq_b_mask_q)})
      else $error("line B mask readback wrong");
   AST_RD_LEVEL: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_LEVEL) |=> wb_dat_o == {16'h0000, $past(level_q)})
      else $error("level readback wrong");
   AST_RD_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_FLAGS) |=> wb_dat_o == {16'h0000, $past(flags)})
      else $error("flag readback wrong");
   AST_RD_DRIVE_EN: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_DRIVE_EN) |=> wb_dat_o == {16'h0000, $past(drive_en_q)})
      else $error("drive enable readback wrong");
   AST_RD_DRIVE_LVL: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_DRIVE_LVL) |=> wb_dat_o == {16'h0000, $past(drive_lvl_q)})
      else $error("drive level readback wrong");
   AST_RD_PULL: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_PULL_EN) |=> wb_dat_o == {16'h0000, $past(pull_en_q)})
      else $error("pull enable readback wrong");
   AST_RD_POLARITY: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_POLARITY) |=> wb_dat_o == {16'h0000, $past(polarity_q)})
      else $error("polarity readback wrong");
   AST_RD_INPUT_EN: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && !wb_req.we && wb_req.adr == GPE_OFS_INPUT_EN) |=> wb_dat_o == {16'h0000, $past(input_en_q)})
      else $error("input enable readback wrong");

   // ----------------------------------------
   // Register write checks
   // ----------------------------------------
   // Full-width writes land on the edge that takes them.
   AST_WR_A_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_IRQ_A_MASK && wmask == 16'hffff) |=> irq_a_mask_q == $past(wb_req.dat[15:0]))
      else $error("line A mask write lost");
   AST_WR_B_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_IRQ_B_MASK && wmask == 16'hffff) |=> irq_b_mask_q == $past(wb_req.dat[15:0]))
      else $error("line B mask write lost");
   AST_WR_POLARITY: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_POLARITY && wmask == 16'hffff) |=> polarity_q == $past(wb_req.dat[15:0]))
      else $error("polarity write lost");
   AST_WR_INPUT_EN: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_INPUT_EN && wmask == 16'hffff) |=> input_en_q == $past(wb_req.dat[15:0]))
      else $error("input enable write lost");

   // A byte lane whose select is low must keep its old contents.
   AST_WR_LANE: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr && wb_req.adr == GPE_OFS_IRQ_A_MASK && !wb_req.sel[1]) |=> irq_a_mask_q[15:8] == $past(irq_a_mask_q[15:8]))
      else $error("unselected lane written");

   // ----------------------------------------
   // Per-pin event checks
   // ----------------------------------------
   // An independent copy of the edge detector, so a broken pin cell is caught.
   logic [15:0] level_prev_q;
   logic [15:0] edge_sel;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_prev_q <= GPE_RST_ZERO;
      end else begin
         level_prev_q <= level_q;
      end
   end

   assign edge_sel = (polarity_q & level_q & ~level_prev_q) | (~polarity_q & ~level_q & level_prev_q);

   genvar k;
   generate
      for (k = 0; k < GPE_PINS; k++) begin : g_chk
         // The selected edge always sets the flag, even against a clear.
         AST_EDGE_SETS: assert property (@(posedge core_clk) disable iff (!reset_n)
            edge_sel[k] |=> flags[k])
            else $error("selected edge did not set flag");
         AST_NO_FALSE_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
            (!flags[k] && !edge_sel[k]) |=> !flags[k])
            else $error("flag set without selected edge");
         AST_HOLD_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            (flags[k] && !clr[k]) |=> flags[k])
            else $error("flag dropped without clear");
         AST_CLEAR_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            (clr[k] && !edge_sel[k]) |=> !flags[k])
            else $error("write one did not clear flag");
         // Lines follow flags and masks in the same cycle, with no extra delay.
         AST_IRQ_A_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            (flags[k] && irq_a_mask_q[k]) |-> irq_a)
            else $error("line A missing for flagged pin");
         AST_IRQ_B_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            (flags[k] && irq_b_mask_q[k]) |-> irq_b)
            else $error("line B missing for flagged pin");
         AST_GATE_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            !$past(input_en_q[k]) |-> !level_q[k])
            else $error("disabled input visible");
         AST_PAD_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            pad_out.drive_enable_n[k] == !drive_en_q[k])
            else $error("driver enable does not follow register");
         AST_LVL_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            pad_out.drive_level[k] == drive_lvl_q[k])
            else $error("pin level does not follow register");
         AST_PULL_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
            pad_out.pull_enable[k] == pull_en_q[k])
            else $error("pull does not follow register");
      end
   endgenerate
endmodule
`default_nettype wire

// ### verification/gpe_board.sv
// Board model for the port pins: pad drivers, external sources, pulls.
// Assumes pull resistors pull up and an undriven, unpulled pin drifts.
`timescale 1ns/1ps
`default_nettype none
module gpe_board (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire gpe_pkg::gpe_pad_out_type pad_out,
   input wire logic [15:0] ext_drive,
   input wire logic [15:0] ext_level,
   output logic [15:0] pin_in
);
   import gpe_pkg::*;
   logic [15:0] float_q;
   // A floating pin changes every cycle so a stale value never looks valid.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         float_q <= 16'h5555;
      end else begin
         float_q <= ~float_q;
      end
   end
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (!pad_out.drive_enable_n[i]) begin
            pin_in[i] = pad_out.drive_level[i];
         end else if (ext_drive[i]) begin
            pin_in[i] = ext_level[i];
         end else begin
            pin_in[i] = pad_out.pull_enable[i] | float_q[i];
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/test_gpe_port.sv
// Self-checking bench for the 16-pin port block.
// Assumes the board model on the pins and a one-cycle Wishbone answer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %0t: got %h exp %h", $time, g, e); end end
module test_gpe_port;
   import gpe_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} gpe_row_type;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   gpe_wb_req_type req = '0;
   logic [31:0] rd;
   logic ack;
   logic irq_a;
   logic irq_b;
   logic [15:0] pin_in;
   logic [15:0] ext_level = 16'h0000;
   gpe_pad_out_type pad;
   logic [31:0] q;
   int error_cnt = 0;
   int n_compared = 0;
   gpe_row_type rows [8] = '{
      '{8'h00, 32'hffff1234, 32'h00001234}, '{8'h04, 32'h0000abcd, 32'h0000abcd},
      '{8'h10, 32'hffff00ff, 32'h000000ff}, '{8'h14, 32'h12345a5a, 32'h00005a5a},
      '{8'h18, 32'hffffc3c3, 32'h0000c3c3}, '{8'h1c, 32'h00008001, 32'h00008001},
      '{8'h20, 32'hffff0f0f, 32'h00000f0f}, '{8'h24, 32'hffffffff, 32'h00000000}};
   always #5 core_clk = ~core_clk;
   gpe_port dut (.core_clk(core_clk), .reset_n(reset_n), .wb_req(req), .wb_dat_o(rd), .wb_ack_o(ack),
      .pin_in(pin_in), .pad_out(pad), .irq_a(irq_a), .irq_b(irq_b));
   gpe_board board (.core_clk(core_clk), .reset_n(reset_n), .pad_out(pad), .ext_drive(16'hff00),
      .ext_level(ext_level), .pin_in(pin_in));
   // ----------------------------------------
   // Bus and closing tasks
   // ----------------------------------------
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      req <= '{1'b1, 1'b1, we, 4'hf, a, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         end_of_test();
      end
      q = rd;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic settle;
      repeat (3) @(posedge core_clk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      `CHK(pad, {16'h0000, 16'hffff, 16'h0000})
      reset_n <= 1'b1;
      for (int i = 0; i <= 8; i++) rd_chk(8'(i * 4), 32'h0);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, rows[i].a, rows[i].w);
         rd_chk(rows[i].a, rows[i].e);
      end
      bus(1'b1, GPE_OFS_DRIVE_EN, 32'h00ff);
      bus(1'b1, GPE_OFS_DRIVE_LVL, 32'h0f0f);
      bus(1'b1, GPE_OFS_PULL_EN, 32'hf000);
      bus(1'b1, GPE_OFS_INPUT_EN, 32'h00ff);
      `CHK(pad, {16'h0f0f, 16'hff00, 16'hf000})
      bus(1'b1, GPE_OFS_LEVEL, 32'hffff);
      rd_chk(GPE_OFS_LEVEL, 32'h000f);
      ext_level <= 16'h0200;
      bus(1'b1, GPE_OFS_POLARITY, 32'h0500);
      bus(1'b1, GPE_OFS_IRQ_A_MASK, 32'h0100);
      bus(1'b1, GPE_OFS_IRQ_B_MASK, 32'h0200);
      bus(1'b1, GPE_OFS_INPUT_EN, 32'hff00);
      settle();
      bus(1'b1, GPE_OFS_FLAGS, 32'hffff);
      rd_chk(GPE_OFS_FLAGS, 32'h0);
      `CHK({irq_a, irq_b}, 2'b00)
      // Pin 8 and 10 rise, pin 9 falls; pin 10 has no mask bit set.
      ext_level <= 16'h0500;
      settle();
      `CHK({irq_a, irq_b}, 2'b11)
      rd_chk(GPE_OFS_FLAGS, 32'h0700);
      @(posedge core_clk);
      ext_level <= 16'h0200;
      settle();
      rd_chk(GPE_OFS_FLAGS, 32'h0700);
      bus(1'b1, GPE_OFS_FLAGS, 32'h0100);
      `CHK({irq_a, irq_b}, 2'b01)
      rd_chk(GPE_OFS_FLAGS, 32'h0600);
      bus(1'b1, GPE_OFS_IRQ_B_MASK, 32'h0);
      `CHK(irq_b, 1'b0)
      // A reset in mid-run must drop flags, lines and pad controls.
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK(pad, {16'h0000, 16'hffff, 16'h0000})
      `CHK({irq_a, irq_b}, 2'b00)
      reset_n <= 1'b1;
      rd_chk(GPE_OFS_FLAGS, 32'h0);
      rd_chk(GPE_OFS_INPUT_EN, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
